// [logic/gbeph_defines.vh]
// register offsets, field positions, reset values and timing counts for the phy power block
`ifndef GBEPH_DEFINES_VH
`define GBEPH_DEFINES_VH
// register byte offsets
`define GBEPH_CTRL_OFF        12'h000
`define GBEPH_POLICY_OFF      12'h004
`define GBEPH_STATUS_OFF      12'h008
`define GBEPH_ERR_CTL_OFF     12'h00c
`define GBEPH_LINK_CFG_OFF    12'h010
// control register fields
`define GBEPH_CTRL_NVM_DONE   0
`define GBEPH_CTRL_ENABLE     1
`define GBEPH_CTRL_MGMT_REQ   2
`define GBEPH_CTRL_PHY_NEED   3
`define GBEPH_CTRL_D3         4
`define GBEPH_CTRL_RESET      32'h0000_0002
// policy register fields
`define GBEPH_POL_AG3         0
`define GBEPH_POL_SX          1
`define GBEPH_POL_DSX_DIS     2
`define GBEPH_POL_BAT_DIS     3
`define GBEPH_POL_RESET       4'h0
// error control fields
`define GBEPH_ERR_URD         0
`define GBEPH_ERR_CAD         1
// link configuration: speed and duplex, serial link rate
`define GBEPH_SPD_10          2'h0
`define GBEPH_SPD_100         2'h1
`define GBEPH_SPD_1000        2'h2
`define GBEPH_SML_100K        2'h0
`define GBEPH_SML_400K        2'h1
`define GBEPH_SML_1M          2'h2
// clock and serial link rates in khz
`define GBEPH_PCLK_KHZ        250000
`define GBEPH_SML_100K_KHZ    100
`define GBEPH_SML_400K_KHZ    400
`define GBEPH_SML_1M_KHZ      1000
`define GBEPH_DIV_100K        ((`GBEPH_PCLK_KHZ) / (`GBEPH_SML_100K_KHZ))
`define GBEPH_DIV_400K        ((`GBEPH_PCLK_KHZ) / (`GBEPH_SML_400K_KHZ))
`define GBEPH_DIV_1M          ((`GBEPH_PCLK_KHZ) / (`GBEPH_SML_1M_KHZ))
// system power states
`define GBEPH_PS_S0           3'h0
`define GBEPH_PS_S0IX         3'h1
`define GBEPH_PS_SX           3'h2
`define GBEPH_PS_DSX          3'h3
`define GBEPH_PS_G3           3'h4
// completion status codes
`define GBEPH_CPL_SC          3'h0
`define GBEPH_CPL_UR          3'h1
`define GBEPH_CPL_CRS         3'h2
`define GBEPH_CPL_CA          3'h4
`endif

// [logic/gbeph_sml_div.v]
// serial link bit-rate divider giving one-cycle enable pulses
`include "gbeph_defines.vh"
`default_nettype none
module gbeph_sml_div (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // rate select
    input  wire [1:0]  rate_sel,
    // tick out
    output reg         bit_tick
);
    reg  [17:0] cnt_r;
    reg  [17:0] limit;

    // divide ratios per rate, cut to the counter width where used
    localparam integer DIV_100K = `GBEPH_DIV_100K;
    localparam integer DIV_400K = `GBEPH_DIV_400K;
    localparam integer DIV_1M   = `GBEPH_DIV_1M;

    // pick the terminal count for the chosen rate
    always @* begin
        case (rate_sel)
            `GBEPH_SML_400K: limit = DIV_400K[17:0] - 18'd1;
            `GBEPH_SML_1M:   limit = DIV_1M[17:0] - 18'd1;
            default:         limit = DIV_100K[17:0] - 18'd1;
        endcase
    end

    // count up one bit period, pulse at the end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r    <= 18'h0_0000;
            bit_tick <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r    <= 18'h0_0000;
            bit_tick <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 18'd1;
            bit_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [logic/gbeph_top.v]
// phy power sequencing and host request error handling for the ethernet controller
//
// Function
// - config requests get retry status until nonvolatile load finishes
// - requests breaking the programming model are dropped; non-posted get abort
// - unsupported requests are dropped; non-posted get unsupported-request status
// - an unsupported request sets the unsupported-request-detected error flag
// - half and full duplex at 10/100, full duplex only at 1000
// - traffic over fast link in S0; serial link in S0ix and Sx
// - network wake raises an internal host wake signal
// - only D0 and D3; in D3 only config accesses are accepted
// - phy sleep control high while enabled and either sleep input is high
// - management request keeps phy powered in Sx or Deep Sx
// - after G3 phy powered only when the post-G3 enable is set
// - in regular Sx phy powered only when the Sx enable is set
// - in Deep Sx phy powered only while the Deep Sx disable is clear
// - on battery with battery disable set the phy is unpowered
// - decision re-evaluated on every state change or AC change
// - power control low puts the phy in low power when unneeded
// - power control low only while sleep control is high
// - sleep control high means phy must be powered when enabled
// - disabled controller drives sleep control low in every state
// - serial link rate selectable as 100k, 400k or 1M
//
// Our own choices: the address map and register access over APB.
`include "gbeph_defines.vh"
`default_nettype none
module gbeph_top (
    // apb clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // host request sideband
    input  wire        req_valid,
    input  wire        req_is_cfg,
    input  wire        req_posted,
    input  wire        req_unsupported,
    input  wire        req_bad_model,
    output reg         cpl_valid,
    output reg  [2:0]  cpl_status,
    output reg         req_accept,
    // power state inputs from pins
    input  wire        sleep_s3_n,
    input  wire        sleep_mgmt_n,
    input  wire        ac_present_a,
    input  wire [2:0]  sys_state,
    input  wire        phy_wake_n,
    // phy control outputs
    output reg         phy_sleep_ctl_n,
    output reg         phy_power_ctl,
    output reg         host_wake,
    output wire        link_fast_sel,
    output wire        sml_bit_tick
);
    reg  [31:0] ctrl_r;
    reg  [3:0]  policy_r;
    reg  [1:0]  err_r;
    reg  [4:0]  link_cfg_r;
    reg  [3:0]  sync1_r;
    reg  [3:0]  sync2_r;
    reg  [2:0]  st1_r;
    reg  [2:0]  st2_r;
    reg  [2:0]  st_prev_r;
    reg         ac_prev_r;
    reg         wake_prev_r;
    reg         eval_r;
    reg         slp_nxt;

    wire        wr_en;
    wire        rd_en;
    wire        s3_s;
    wire        mgmt_s;
    wire        ac_s;
    wire        wake_s;
    wire        nvm_done;
    wire        enabled;
    wire        in_d3;
    wire        ur_hit;
    wire        ca_hit;
    wire        slp_upd;
    wire        slp_eff;

    // decode one register offset
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // apb strobes: zero-wait slave
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & ~(hit(paddr, `GBEPH_CTRL_OFF)
                     | hit(paddr, `GBEPH_POLICY_OFF) | hit(paddr, `GBEPH_STATUS_OFF)
                     | hit(paddr, `GBEPH_ERR_CTL_OFF) | hit(paddr, `GBEPH_LINK_CFG_OFF));

    // two-flop synchronisers for pin inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 4'hf;
            sync2_r <= 4'hf;
            st1_r   <= 3'h0;
            st2_r   <= 3'h0;
        end else begin
            sync1_r <= {sleep_s3_n, sleep_mgmt_n, ac_present_a, phy_wake_n};
            sync2_r <= sync1_r;
            st1_r   <= sys_state;
            st2_r   <= st1_r;
        end
    end
    assign s3_s   = sync2_r[3];
    assign mgmt_s = sync2_r[2];
    assign ac_s   = sync2_r[1];
    assign wake_s = sync2_r[0];

    assign nvm_done = ctrl_r[`GBEPH_CTRL_NVM_DONE];
    assign enabled  = ctrl_r[`GBEPH_CTRL_ENABLE];
    assign in_d3    = ctrl_r[`GBEPH_CTRL_D3];

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `GBEPH_CTRL_RESET;
            policy_r   <= `GBEPH_POL_RESET;
            link_cfg_r <= 5'h00;
        end else if (wr_en) begin
            if (hit(paddr, `GBEPH_CTRL_OFF))
                ctrl_r <= {27'h000_0000, pwdata[4:0]};
            if (hit(paddr, `GBEPH_POLICY_OFF))
                policy_r <= pwdata[3:0];
            if (hit(paddr, `GBEPH_LINK_CFG_OFF)) begin
                // 1000 forces full duplex
                link_cfg_r[1:0] <= pwdata[1:0];
                link_cfg_r[2]   <= pwdata[2] | (pwdata[1:0] == `GBEPH_SPD_1000);
                link_cfg_r[4:3] <= pwdata[4:3];
            end
        end
    end

    // request classification
    // unsupported is checked first so one request never raises both flags
    assign ur_hit = req_valid & nvm_done & req_unsupported;
    assign ca_hit = req_valid & nvm_done & ~req_unsupported
                    & (req_bad_model | (in_d3 & ~req_is_cfg));

    // sticky error flags, set wins over write-one-to-clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_r <= 2'b00;
        end else begin
            if (ur_hit)
                err_r[`GBEPH_ERR_URD] <= 1'b1;
            else if (wr_en & hit(paddr, `GBEPH_ERR_CTL_OFF) & pwdata[`GBEPH_ERR_URD])
                err_r[`GBEPH_ERR_URD] <= 1'b0;
            if (ca_hit)
                err_r[`GBEPH_ERR_CAD] <= 1'b1;
            else if (wr_en & hit(paddr, `GBEPH_ERR_CTL_OFF) & pwdata[`GBEPH_ERR_CAD])
                err_r[`GBEPH_ERR_CAD] <= 1'b0;
        end
    end

    // completion generation, one cycle after the request
    // before the load finishes only config requests get an answer (retry)
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpl_valid  <= 1'b0;
            cpl_status <= `GBEPH_CPL_SC;
            req_accept <= 1'b0;
        end else begin
            cpl_valid  <= 1'b0;
            req_accept <= 1'b0;
            if (req_valid) begin
                if (!nvm_done) begin
                    cpl_valid  <= req_is_cfg;
                    cpl_status <= `GBEPH_CPL_CRS;
                end else if (ur_hit) begin
                    cpl_valid  <= ~req_posted;
                    cpl_status <= `GBEPH_CPL_UR;
                end else if (ca_hit) begin
                    cpl_valid  <= ~req_posted;
                    cpl_status <= `GBEPH_CPL_CA;
                end else begin
                    req_accept <= 1'b1;
                    cpl_valid  <= ~req_posted;
                    cpl_status <= `GBEPH_CPL_SC;
                end
            end
        end
    end

    // fast link only in S0, serial link otherwise
    assign link_fast_sel = (st2_r == `GBEPH_PS_S0);

    // change detect on state and ac presence
    // previous-value resets match idle pin levels, so no false edge after reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_prev_r   <= 3'h0;
            ac_prev_r   <= 1'b1;
            wake_prev_r <= 1'b1;
            eval_r      <= 1'b1;
            host_wake   <= 1'b0;
        end else begin
            st_prev_r   <= st2_r;
            ac_prev_r   <= ac_s;
            wake_prev_r <= wake_s;
            eval_r      <= (st2_r != st_prev_r) | (ac_s != ac_prev_r);
            host_wake   <= wake_prev_r & ~wake_s;
        end
    end

    // sleep control policy decision
    always @* begin
        if (!enabled)
            slp_nxt = 1'b0;
        else if (s3_s | mgmt_s)
            slp_nxt = 1'b1;
        else if (ctrl_r[`GBEPH_CTRL_MGMT_REQ])
            slp_nxt = 1'b1;
        else begin
            case (st2_r)
                `GBEPH_PS_G3:  slp_nxt = policy_r[`GBEPH_POL_AG3];
                `GBEPH_PS_SX:  slp_nxt = policy_r[`GBEPH_POL_SX];
                `GBEPH_PS_DSX: slp_nxt = ~policy_r[`GBEPH_POL_DSX_DIS];
                default:       slp_nxt = 1'b1;
            endcase
            // battery check overrides the state policy, not the management request
            if (!ac_s & policy_r[`GBEPH_POL_BAT_DIS])
                slp_nxt = 1'b0;
        end
    end

    // sleep control takes a new value only on evaluation events or forcing inputs
    assign slp_upd = eval_r | ~enabled | s3_s | mgmt_s;
    assign slp_eff = slp_upd ? slp_nxt : phy_sleep_ctl_n;

    // sleep control updates on evaluation events, while disabled or while a sleep input is high; power control every cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_sleep_ctl_n <= 1'b0;
            phy_power_ctl   <= 1'b1;
        end else begin
            phy_sleep_ctl_n <= slp_eff;
            // power control uses the sleep value launched at this same edge,
            // so it never sits low while sleep control is low
            phy_power_ctl <= ~(slp_eff & enabled
                             & ~ctrl_r[`GBEPH_CTRL_PHY_NEED]);
        end
    end

    // register reads
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, `GBEPH_CTRL_OFF))
                prdata <= ctrl_r;
            if (hit(paddr, `GBEPH_POLICY_OFF))
                prdata <= {28'h000_0000, policy_r};
            if (hit(paddr, `GBEPH_STATUS_OFF))
                prdata <= {22'h00_0000, st2_r, link_fast_sel, wake_s, ac_s,
                           mgmt_s, s3_s, phy_power_ctl, phy_sleep_ctl_n};
            if (hit(paddr, `GBEPH_ERR_CTL_OFF))
                prdata <= {30'h0000_0000, err_r};
            if (hit(paddr, `GBEPH_LINK_CFG_OFF))
                prdata <= {27'h000_0000, link_cfg_r};
        end
    end

    // serial link bit clock enable
    gbeph_sml_div gbeph_sml_div_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .rate_sel (link_cfg_r[4:3]),
        .bit_tick (sml_bit_tick)
    );
endmodule
`default_nettype wire

// [bench/gbeph_top_monitor.sv]
// port-level assertions for the phy power and host error block
`default_nettype none
`include "gbeph_defines.vh"
module gbeph_top_monitor (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // host requests and completions
    input wire logic       req_valid,
    input wire logic       req_is_cfg,
    input wire logic       req_posted,
    input wire logic       req_unsupported,
    input wire logic       req_bad_model,
    input wire logic       cpl_valid,
    input wire logic [2:0] cpl_status,
    // phy pins and state
    input wire logic       phy_sleep_ctl_n,
    input wire logic       phy_power_ctl,
    input wire logic       phy_wake_n,
    input wire logic       host_wake,
    input wire logic [2:0] sys_state,
    input wire logic       link_fast_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_cfg_answered: assert property (
        req_valid && req_is_cfg && !req_posted |=> cpl_valid) else $error("cfg not answered");
    chk_ur_status: assert property (
        req_valid && !req_posted && req_unsupported |=> !cpl_valid
        || cpl_status == `GBEPH_CPL_UR || cpl_status == `GBEPH_CPL_CRS) else $error("bad ur");
    chk_ca_status: assert property (
        req_valid && !req_posted && req_bad_model && !req_unsupported |=> !cpl_valid
        || cpl_status == `GBEPH_CPL_CA || cpl_status == `GBEPH_CPL_CRS) else $error("bad ca");
    chk_posted_quiet: assert property (
        req_valid && req_posted |=> !cpl_valid) else $error("posted completed");
    chk_cpl_cause: assert property (
        cpl_valid |-> $past(req_valid)) else $error("stray completion");
    chk_power_gate: assert property (
        !phy_power_ctl |-> phy_sleep_ctl_n) else $error("power ctl low while asleep");
    chk_wake_seen: assert property (
        $fell(phy_wake_n) |-> ##[1:5] host_wake) else $error("wake lost");
    chk_wake_pulse: assert property (
        host_wake |=> !host_wake) else $error("wake not a pulse");
    chk_fast_s0: assert property (
        (sys_state == `GBEPH_PS_S0)[*4] |-> link_fast_sel) else $error("fast link off in s0");
    chk_slow_sx: assert property (
        (sys_state != `GBEPH_PS_S0)[*4] |-> !link_fast_sel) else $error("fast link outside s0");
endmodule
bind gbeph_top gbeph_top_monitor gbeph_top_monitor_inst (.pclk, .presetn, .req_valid,
    .req_is_cfg, .req_posted, .req_unsupported, .req_bad_model, .cpl_valid, .cpl_status,
    .phy_sleep_ctl_n, .phy_power_ctl, .phy_wake_n, .host_wake, .sys_state, .link_fast_sel);
`default_nettype wire

// [bench/gbeph_phy_model.sv]
// external phy model: wakes only while powered, wake pin pulled up otherwise
`default_nettype none
module gbeph_phy_model (
    // clock
    input  wire logic pclk,
    // power pins from the block
    input  wire logic phy_sleep_ctl_n,
    input  wire logic phy_power_ctl,
    // wake command from the bench
    input  wire logic wake_req,
    // open-drain wake pin
    output wire logic phy_wake_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // pull low four cycles, only from a powered phy
    always @(posedge pclk) begin
        if (wake_req && phy_sleep_ctl_n && phy_power_ctl) cnt <= 4;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign phy_wake_n = (cnt == 0);
endmodule
`default_nettype wire

// [bench/gbeph_top_tb_top.sv]
// register, request and phy power tests for the phy power block
`default_nettype none
`include "gbeph_defines.vh"
module gbeph_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        req_valid, req_is_cfg, req_posted, req_unsupported, req_bad_model;
    logic        cpl_valid, req_accept, sleep_s3_n, sleep_mgmt_n, ac_present_a, phy_wake_n;
    logic [2:0]  cpl_status, sys_state;
    logic        phy_sleep_ctl_n, phy_power_ctl, host_wake, link_fast_sel, sml_bit_tick;
    logic        wake_req, en;
    int          n_mismatch, compares, n;
    int          divs [3] = '{`GBEPH_DIV_100K, `GBEPH_DIV_400K, `GBEPH_DIV_1M};
    // rows {s3, mgmt sleep, enable, mgmt req, ac, policy[3:0], state}
    logic [11:0] rows [12] = '{12'ha80, 12'h680, 12'h282, 12'h292, 12'h284, 12'h28c,
                               12'h283, 12'h2a3, 12'h252, 12'h2d2, 12'h342, 12'h092};
    gbeph_top gbeph_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .req_valid, .req_is_cfg, .req_posted, .req_unsupported,
        .req_bad_model, .cpl_valid, .cpl_status, .req_accept, .sleep_s3_n, .sleep_mgmt_n,
        .ac_present_a, .sys_state, .phy_wake_n, .phy_sleep_ctl_n, .phy_power_ctl,
        .host_wake, .link_fast_sel, .sml_bit_tick);
    gbeph_phy_model gbeph_phy_model_inst (.pclk, .phy_sleep_ctl_n, .phy_power_ctl,
        .wake_req, .phy_wake_n);
    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // compare and report at once
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // apb transfer held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_v, e);
    endtask
    // one host request {cfg, posted, unsupported, bad model}
    task automatic rq(input logic [3:0] q, input logic v, input logic [2:0] s);
        @(posedge pclk);
        {req_is_cfg, req_posted, req_unsupported, req_bad_model} <= q;
        req_valid <= 1'b1;
        @(posedge pclk);
        req_valid <= 1'b0;
        #1;
        chk({31'b0, cpl_valid}, {31'b0, v});
        if (v) chk({29'b0, cpl_status}, {29'b0, s});
        chk({31'b0, req_accept}, {31'b0, s == `GBEPH_CPL_SC && (v || q[2])});
    endtask
    // expected sleep control for one row
    function automatic logic exp_sl(input logic [11:0] r);
        logic [3:0] p;
        p = r[6:3];
        if (!r[9]) return 1'b0;
        if (r[11] || r[10] || r[8]) return 1'b1;
        if (r[2:0] == `GBEPH_PS_G3) return p[0] && (r[7] || !p[3]);
        if (r[2:0] == `GBEPH_PS_DSX) return !p[2] && (r[7] || !p[3]);
        return p[1] && (r[7] || !p[3]);
    endfunction
    task tally_and_finish;
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, req_valid, wake_req} = '0;
        {req_is_cfg, req_posted, req_unsupported, req_bad_model} = 4'h0;
        {sleep_s3_n, sleep_mgmt_n, ac_present_a, sys_state} = 6'h08;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`GBEPH_POLICY_OFF, 32'h0000_0000);
        rq(4'h8, 1'b1, `GBEPH_CPL_CRS);
        rq(4'h0, 1'b0, `GBEPH_CPL_SC);
        wr(`GBEPH_CTRL_OFF, 32'h0000_0003);
        rq(4'h8, 1'b1, `GBEPH_CPL_SC);
        rq(4'h2, 1'b1, `GBEPH_CPL_UR);
        rd(`GBEPH_ERR_CTL_OFF, 32'h0000_0001);
        wr(`GBEPH_ERR_CTL_OFF, 32'h0000_0001);
        rd(`GBEPH_ERR_CTL_OFF, 32'h0000_0000);
        rq(4'h1, 1'b1, `GBEPH_CPL_CA);
        rq(4'h6, 1'b0, `GBEPH_CPL_UR);
        rq(4'h5, 1'b0, `GBEPH_CPL_CA);
        rq(4'h4, 1'b0, `GBEPH_CPL_SC);
        wr(`GBEPH_CTRL_OFF, 32'h0000_0013);
        rq(4'h0, 1'b1, `GBEPH_CPL_CA);
        rq(4'h8, 1'b1, `GBEPH_CPL_SC);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk({31'b0, err_v}, 32'h0000_0001);
        chk(rd_v, 32'h0000_0000);
        wr(`GBEPH_LINK_CFG_OFF, 32'h0000_0002);
        rd(`GBEPH_LINK_CFG_OFF, 32'h0000_0006);
        wr(`GBEPH_LINK_CFG_OFF, 32'h0000_0001);
        rd(`GBEPH_LINK_CFG_OFF, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            wr(`GBEPH_LINK_CFG_OFF, {27'b0, 2'(k), 3'b110});
            repeat (2) @(posedge pclk iff sml_bit_tick === 1'b1);
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (sml_bit_tick !== 1'b1 && n < 5000);
            chk(n, divs[k]);
        end
        foreach (rows[i]) begin
            // leave the target state first so each row ends in a transition
            @(posedge pclk);
            sys_state <= `GBEPH_PS_S0IX;
            wr(`GBEPH_POLICY_OFF, {28'b0, rows[i][6:3]});
            wr(`GBEPH_CTRL_OFF, {29'b0, rows[i][8], rows[i][9], 1'b1});
            {sleep_s3_n, sleep_mgmt_n} <= rows[i][11:10];
            ac_present_a <= rows[i][7];
            sys_state <= rows[i][2:0];
            repeat (8) @(posedge pclk);
            #1;
            en = rows[i][9];
            chk(phy_sleep_ctl_n, exp_sl(rows[i]));
            chk(phy_power_ctl, !(exp_sl(rows[i]) && en));
            chk(link_fast_sel, rows[i][2:0] == `GBEPH_PS_S0);
        end
        wr(`GBEPH_CTRL_OFF, 32'h0000_000b);
        sleep_s3_n <= 1'b1;
        repeat (8) @(posedge pclk);
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        n = 0;
        repeat (10) @(posedge pclk) if (host_wake === 1'b1) n++;
        chk(n, 1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
